// ===== src/fault_sup_pkg.sv
/*
 Constants and types shared by the fault supervisor design files.
 Assumes a single switching-rate clock and comparator flags from the analog front end.
*/
package fault_sup_pkg;

   // ****************************************
   // Over-current cycle windows
   // ****************************************
   localparam int unsigned OC_SKIP_CYCLES  = 8;
   localparam int unsigned OC_WATCH_CYCLES = 8;
   localparam int unsigned OC_RESET_CYCLES = 16;
   localparam int unsigned OC_CNT_W        = 5;
   localparam logic [4:0]  OC_SKIP_END     = 5'(OC_SKIP_CYCLES);
   localparam logic [4:0]  OC_WATCH_END    = 5'(OC_SKIP_CYCLES + OC_WATCH_CYCLES);
   localparam logic [4:0]  OC_RESET_END    = 5'(OC_RESET_CYCLES);

   // ****************************************
   // Thresholds, for reference only
   // ****************************************
   localparam int unsigned OV_LIMIT_MV     = 1900;
   localparam int unsigned HOT_TRIP_DEGC   = 150;
   localparam int unsigned HOT_CLEAR_DEGC  = 125;

   // ****************************************
   // Synchroniser and reset values
   // ****************************************
   localparam int unsigned SYNC_STAGES     = 3;
   localparam int unsigned NUM_FLAGS       = 5;
   localparam logic [4:0]  FLAG_RESET      = 5'h00;
   localparam logic [4:0]  CNT_RESET       = 5'h00;

   // Flag positions in the synchronised vector
   localparam int unsigned FLAG_OC   = 0;
   localparam int unsigned FLAG_UV   = 1;
   localparam int unsigned FLAG_OV   = 2;
   localparam int unsigned FLAG_HOT  = 3;
   localparam int unsigned FLAG_COOL = 4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SOFTSTART,
      ST_RUN,
      ST_LATCHED,
      ST_THERMAL
   } sup_state_t;

   typedef enum logic [1:0] {
      OC_QUIET,
      OC_SKIP,
      OC_WATCH,
      OC_SETTLE
   } oc_state_t;

endpackage : fault_sup_pkg

// ===== src/flag_sync.sv
/*
 Three-stage synchroniser with agreement filter for a vector of comparator flags.
 Assumes inputs are asynchronous to core_clk; output changes once stages two and three agree.
*/
`timescale 1ns/100ps
`default_nettype none
module flag_sync
   import fault_sup_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   // Flags
   input  wire logic [NUM_FLAGS-1:0] rawFlags,
   output var  logic [NUM_FLAGS-1:0] syncFlags
);
   import fault_sup_pkg::*;

   genvar i;
   generate
      for (i = 0; i < NUM_FLAGS; i++)
      begin : g_flag
         logic [SYNC_STAGES-1:0] stage_r;
         always_ff @(posedge core_clk or negedge rst_b)
         begin
            if (!rst_b)
               stage_r <= '0;
            else
               stage_r <= {stage_r[SYNC_STAGES-2:0], rawFlags[i]};
         end
         // Only the second and third stages are compared
         always_ff @(posedge core_clk or negedge rst_b)
         begin
            if (!rst_b)
               syncFlags[i] <= 1'b0;
            else if (stage_r[1] == stage_r[2])
               syncFlags[i] <= stage_r[2];
         end
      end
   endgenerate

endmodule : flag_sync
`default_nettype wire

// ===== src/buck_fault_supervisor.sv
/*
 Fault supervisor for a synchronous buck controller: over-current pulse skipping and latch,
 under-voltage and overload latch-off, non-latching over-voltage low-side force, thermal
 shutdown with soft-start restart, and the power-ok output.
 Assumes core_clk is the switching clock, comparator flags arrive asynchronously, and the
 PWM modulator and soft-start ramp live outside and report through plain ports.
*/
// Functional notes
// (R1) A sustained overload drops power ok and latches the whole controller off.
// (R2) The latch holds until supply cycling (reset) or an enable toggle clears it.
// (R3) An over-current trip starts pulse skipping; high-side stays off while current is high; the code holds it off in the quiet and skip states only.
// (R4) Skipping lasts eight switching cycles counted from the first comparator trip.
// (R5) A new trip in the eight cycles after the first eight latches the fault off.
// (R6) If current clears early, switching resumes and the logic resets sixteen cycles on.
// (R7) Output below the under-voltage threshold shuts the device down at once.
// (R8) Output above 1.9V forces the low-side gate high over normal control.
// (R9) The over-voltage force does not latch and releases as the output recovers.
// (R10) A die-temperature flag at 150C shuts the device down.
// (R11) Restart after thermal shutdown waits for below 125C and runs a full soft start.
// (R12) Comparator inputs are synchronised and sampled once per switching cycle.
// (R13) In any off state both gates are off except the over-voltage force; power ok is low.
`timescale 1ns/100ps
`default_nettype none
module buck_fault_supervisor
   import fault_sup_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // Enable pin
   input  wire logic enablePin,
   // Comparator flags from the analog front end
   input  wire logic overCurrentCmp,
   input  wire logic underVoltageCmp,
   input  wire logic overVoltageCmp,
   input  wire logic dieHotCmp,
   input  wire logic dieCoolCmp,
   input  wire logic sustainedOverloadCmp,
   // Soft-start and modulator status
   input  wire logic softStartDone,
   input  wire logic outputInReg,
   input  wire logic pwmHighReq,
   input  wire logic pwmLowReq,
   // Gate drive and status outputs
   output var  logic highGateOn,
   output var  logic lowGateOn,
   output var  logic softStartGo,
   output var  logic latchedOff,
   output var  logic thermalOff,
   output var  logic power_ok_output
);
   import fault_sup_pkg::*;

   // ****************************************
   // Input synchronisation
   // ****************************************
   logic [NUM_FLAGS-1:0] syncFlags;
   logic [2:0]           enSync_r;
   logic                 enLevel_r;
   logic                 olSync1_r;
   logic                 olSync2_r;
   logic                 olSync3_r;
   logic                 overload_r;

   flag_sync u_flag_sync
   (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .rawFlags  ({dieCoolCmp, dieHotCmp, overVoltageCmp, underVoltageCmp, overCurrentCmp}),
      .syncFlags (syncFlags)
   ); // [R12]

   logic ocFlag;
   logic uvFlag;
   logic ovFlag;
   logic hotFlag;
   logic coolFlag;
   assign ocFlag   = syncFlags[FLAG_OC];
   assign uvFlag   = syncFlags[FLAG_UV];
   assign ovFlag   = syncFlags[FLAG_OV];
   assign hotFlag  = syncFlags[FLAG_HOT];
   assign coolFlag = syncFlags[FLAG_COOL];

   // Enable pin and overload flag use the same three-stage agreement filter
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         enSync_r  <= 3'h0;
         enLevel_r <= 1'b0;
      end
      else
      begin
         enSync_r <= {enSync_r[1:0], enablePin};
         if (enSync_r[1] == enSync_r[2])
            enLevel_r <= enSync_r[2];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         olSync1_r  <= 1'b0;
         olSync2_r  <= 1'b0;
         olSync3_r  <= 1'b0;
         overload_r <= 1'b0;
      end
      else
      begin
         olSync1_r <= sustainedOverloadCmp;
         olSync2_r <= olSync1_r;
         olSync3_r <= olSync2_r;
         if (olSync2_r == olSync3_r)
            overload_r <= olSync3_r;
      end
   end

   // ****************************************
   // Over-current sequencer
   // ****************************************
   oc_state_t         ocState_r;
   logic [OC_CNT_W-1:0] ocCnt_r;
   logic              ocLatch;
   logic              ocSkip;
   logic              ocPrev_r;
   logic              ocRise;
   logic              running;

   assign ocRise = ocFlag && !ocPrev_r;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         ocPrev_r <= 1'b0;
      else
         ocPrev_r <= ocFlag;
   end

   // Count starts at the first trip; sampling is once per switching cycle
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ocState_r <= OC_QUIET;
         ocCnt_r   <= CNT_RESET;
      end
      else if (!running)
      begin
         ocState_r <= OC_QUIET;
         ocCnt_r   <= CNT_RESET;
      end
      else
      begin
         case (ocState_r)
            OC_QUIET:
            begin
               if (ocFlag)
               begin
                  ocState_r <= OC_SKIP; // [R3]
                  ocCnt_r   <= 5'h01;
               end
            end
            OC_SKIP:
            begin
               ocCnt_r <= ocCnt_r + 5'h01;
               if (ocCnt_r == OC_SKIP_END)
                  // Still high at the end of the first window counts as a new trip
                  ocState_r <= OC_WATCH; // [R4]
            end
            OC_WATCH:
            begin
               ocCnt_r <= ocCnt_r + 5'h01;
               if (ocCnt_r == OC_RESET_END)
               begin
                  ocState_r <= OC_QUIET; // [R6]
                  ocCnt_r   <= CNT_RESET;
               end
            end
            default:
            begin
               ocState_r <= OC_QUIET;
               ocCnt_r   <= CNT_RESET;
            end
         endcase
      end
   end

   // Any trip in the second window latches; a level still high counts too
   assign ocLatch = running && (ocState_r == OC_WATCH) && ocFlag; // [R5]
   // High side held off while current is above threshold in the quiet and skip states
   assign ocSkip  = ((ocState_r == OC_SKIP) || (ocState_r == OC_QUIET)) && ocFlag; // [R3]

   // ****************************************
   // Top-level supervisor state
   // ****************************************
   sup_state_t supState_r;
   logic       enPrev_r;
   logic       enToggle;

   assign running  = (supState_r == ST_RUN) || (supState_r == ST_SOFTSTART);
   assign enToggle = enLevel_r && !enPrev_r;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         enPrev_r <= 1'b0;
      else
         enPrev_r <= enLevel_r;
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         supState_r <= ST_IDLE; // [R2]
      else
      begin
         case (supState_r)
            ST_IDLE:
            begin
               if (enLevel_r && hotFlag)
                  supState_r <= ST_THERMAL;
               else if (enToggle)
                  supState_r <= ST_SOFTSTART;
            end
            ST_SOFTSTART, ST_RUN:
            begin
               if (!enLevel_r)
                  supState_r <= ST_IDLE;
               else if (hotFlag)
                  supState_r <= ST_THERMAL; // [R10]
               else if (overload_r || uvFlag || ocLatch)
                  supState_r <= ST_LATCHED; // [R1] [R5] [R7]
               else if (supState_r == ST_SOFTSTART && softStartDone)
                  supState_r <= ST_RUN;
            end
            ST_LATCHED:
            begin
               // Only an enable drop releases; a fresh rising edge then restarts
               if (!enLevel_r)
                  supState_r <= ST_IDLE; // [R2]
            end
            ST_THERMAL:
            begin
               if (!enLevel_r)
                  supState_r <= ST_IDLE;
               else if (coolFlag && !hotFlag)
                  supState_r <= ST_SOFTSTART; // [R11]
            end
            default:
               supState_r <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Gate drive and status outputs
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         highGateOn <= 1'b0;
         lowGateOn  <= 1'b0;
      end
      else
      begin
         // Over-voltage forces low side in every state and never latches
         highGateOn <= running && !ovFlag && !ocSkip && pwmHighReq; // [R3] [R13]
         lowGateOn  <= ovFlag || (running && pwmLowReq); // [R8] [R9] [R13]
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         softStartGo     <= 1'b0;
         latchedOff      <= 1'b0;
         thermalOff      <= 1'b0;
         power_ok_output <= 1'b0;
      end
      else
      begin
         softStartGo     <= (supState_r == ST_SOFTSTART); // [R11]
         latchedOff      <= (supState_r == ST_LATCHED); // [R1]
         thermalOff      <= (supState_r == ST_THERMAL); // [R10]
         power_ok_output <= (supState_r == ST_RUN) && outputInReg && !overload_r; // [R1] [R13]
      end
   end

endmodule : buck_fault_supervisor
`default_nettype wire

// ===== verif/fault_sup_monitor.sv
/*
 Port checker for the fault supervisor, bound to its top module.
 Assumes comparator levels are held for several switching cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module fault_sup_monitor (
   input wire logic core_clk, rst_b, enablePin, overCurrentCmp, underVoltageCmp,
   input wire logic overVoltageCmp, dieHotCmp, sustainedOverloadCmp, highGateOn,
   input wire logic lowGateOn, softStartGo, latchedOff, thermalOff, power_ok_output
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Sync latency is up to five edges, so the over-voltage, over-current and latch-hold checks wait six
   sequence ovHeld;
      $rose(overVoltageCmp) ##1 overVoltageCmp[*6];
   endsequence
   sequence latchHeld;
      (enablePin && !dieHotCmp)[*6] ##0 latchedOff;
   endsequence
   hs_off_latched_a: assert property (latchedOff |-> !highGateOn)
      else $error("high gate on while latched");
   pok_off_low_a: assert property ((latchedOff || thermalOff) |-> !power_ok_output)
      else $error("power ok high while off");
   ov_force_a: assert property (ovHeld |-> lowGateOn)
      else $error("low gate not forced");
   ov_release_a: assert property ((!overVoltageCmp && latchedOff)[*7] |-> !lowGateOn)
      else $error("low gate force kept");
   uv_shutdown_a: assert property ((power_ok_output && underVoltageCmp && !dieHotCmp)[*3]
      |-> ##[0:4] latchedOff) else $error("no undervoltage latch");
   ol_latch_a: assert property ((power_ok_output && sustainedOverloadCmp && !dieHotCmp)[*3]
      |-> ##[0:4] latchedOff) else $error("no overload latch");
   hot_trip_a: assert property ((softStartGo || power_ok_output) && dieHotCmp
      |-> ##[1:6] thermalOff) else $error("no thermal shutdown");
   oc_skip_a: assert property (overCurrentCmp[*6] |-> !highGateOn)
      else $error("high gate on during overcurrent");
   latch_hold_a: assert property (latchHeld |=> latchedOff)
      else $error("latch dropped with enable high");
   cool_restart_a: assert property ($fell(thermalOff) && enablePin |-> softStartGo)
      else $error("thermal exit without soft start");
endmodule : fault_sup_monitor
bind buck_fault_supervisor fault_sup_monitor u_fault_sup_monitor (.core_clk, .rst_b,
   .enablePin, .overCurrentCmp, .underVoltageCmp, .overVoltageCmp, .dieHotCmp,
   .sustainedOverloadCmp, .highGateOn, .lowGateOn, .softStartGo, .latchedOff, .thermalOff,
   .power_ok_output);
`default_nettype wire

// ===== verif/half_bridge_model.sv
/*
 Half-bridge stand-in driven by the two gate outputs.
 Assumes gates change only just after core_clk rising edges.
*/
`timescale 1ns/100ps
`default_nettype none
module half_bridge_model (
   input  wire logic core_clk,
   input  wire logic highGateOn,
   input  wire logic lowGateOn,
   output var  logic phaseNode,
   output var  logic shootSeen
);
   initial shootSeen = 1'b0;
   initial phaseNode = 1'b0;
   // Floating node toggles so a stale level never reads as driven
   always @(posedge core_clk)
   begin
      if (highGateOn && lowGateOn)
         shootSeen <= 1'b1;
      phaseNode <= highGateOn ? 1'b1 : (lowGateOn ? 1'b0 : !phaseNode);
   end
endmodule : half_bridge_model
`default_nettype wire

// ===== verif/buck_fault_supervisor_test.sv
/*
 Self-checking bench for the fault supervisor.
 Assumes comparator levels are held for several switching cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module buck_fault_supervisor_test;
   import fault_sup_pkg::*;
   localparam int HGT = 0, LGT = 1, SSG = 2, LAT = 3, THR = 4, POK = 5, OLD = 5;
   logic       core_clk;
   logic       rst_b;
   logic       enablePin;
   logic       softStartDone;
   logic       pwmHighReq;
   logic [5:0] cmp;
   wire  [5:0] outs;
   wire        phaseNode;
   wire        shootSeen;
   int         seed = 32'hc70ca23a;
   int         n_errors = 0;
   int         cmp_count = 0;
   buck_fault_supervisor u_buck_fault_supervisor (.core_clk, .rst_b, .enablePin,
      .overCurrentCmp(cmp[FLAG_OC]), .underVoltageCmp(cmp[FLAG_UV]),
      .overVoltageCmp(cmp[FLAG_OV]), .dieHotCmp(cmp[FLAG_HOT]), .dieCoolCmp(cmp[FLAG_COOL]),
      .sustainedOverloadCmp(cmp[OLD]), .softStartDone, .outputInReg(1'b1), .pwmHighReq,
      .pwmLowReq(!pwmHighReq), .highGateOn(outs[HGT]), .lowGateOn(outs[LGT]),
      .softStartGo(outs[SSG]), .latchedOff(outs[LAT]), .thermalOff(outs[THR]),
      .power_ok_output(outs[POK]));
   half_bridge_model u_half_bridge_model (.core_clk, .highGateOn(outs[HGT]),
      .lowGateOn(outs[LGT]), .phaseNode, .shootSeen);
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = !core_clk;
   end
   always @(posedge core_clk) pwmHighReq <= 1'($random(seed));
   task automatic chk(input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: saw %b, expected %b", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic set(input int k, input logic v);
      @(posedge core_clk) cmp[k] <= v;
   endtask : set
   // Bounded wait; a timeout is a mismatch and ends the run
   task automatic wait_for(input int k, input logic v);
      int i;
      for (i = 0; i < 40 && outs[k] !== v; i++)
         @(posedge core_clk) #1;
      chk(outs[k], v);
      if (outs[k] !== v)
         finish_test();
   endtask : wait_for
   task automatic start_up;
      @(posedge core_clk) enablePin <= 1'b0;
      cyc(6);
      enablePin <= 1'b1;
      wait_for(SSG, 1'b1);
      @(posedge core_clk) softStartDone <= 1'b1;
      wait_for(POK, 1'b1);
      @(posedge core_clk) softStartDone <= 1'b0;
   endtask : start_up
   initial
   begin
      {rst_b, enablePin, softStartDone, pwmHighReq, cmp} = '0;
      cyc(5);
      rst_b <= 1'b1;
      #1 chk(outs[POK], 1'b0);
      start_up();
      set(FLAG_OC, 1'b1);
      cyc(6);
      set(FLAG_OC, 1'b0);
      cyc(30);
      chk(outs[LAT], 1'b0);
      set(FLAG_OC, 1'b1);
      cyc(3);
      set(FLAG_OC, 1'b0);
      cyc(8);
      set(FLAG_OC, 1'b1);
      cyc(3);
      set(FLAG_OC, 1'b0);
      wait_for(LAT, 1'b1);
      chk(outs[POK], 1'b0);
      set(FLAG_OV, 1'b1);
      wait_for(LGT, 1'b1);
      set(FLAG_OV, 1'b0);
      wait_for(LGT, 1'b0);
      cyc(10);
      chk(outs[LAT], 1'b1);
      start_up();
      foreach (cmp[k])
         if (k == FLAG_UV || k == OLD)
         begin
            set(k, 1'b1);
            wait_for(LAT, 1'b1);
            chk(outs[HGT], 1'b0);
            set(k, 1'b0);
            start_up();
         end
      set(FLAG_HOT, 1'b1);
      wait_for(THR, 1'b1);
      set(FLAG_HOT, 1'b0);
      set(FLAG_COOL, 1'b1);
      wait_for(SSG, 1'b1);
      chk(outs[POK], 1'b0);
      @(posedge core_clk) softStartDone <= 1'b1;
      wait_for(POK, 1'b1);
      rst_b <= 1'b0;
      #1 chk(outs[POK], 1'b0);
      chk(shootSeen, 1'b0);
      finish_test();
   end
endmodule : buck_fault_supervisor_test
`default_nettype wire
